// [hdl/pvb_pkg.sv]
// Shared constants, register map and carrier types for the voltage-code bus slave
package pvb_pkg;
   // Register byte offsets
   localparam logic [7:0] PVB_OFF_CFG = 8'h00;
   localparam logic [7:0] PVB_OFF_BOOT = 8'h04;
   localparam logic [7:0] PVB_OFF_WP0 = 8'h08;
   localparam logic [7:0] PVB_OFF_STATUS = 8'h18;
   localparam logic [7:0] PVB_OFF_REF = 8'h1C;
   localparam int PVB_WP_NUM = 4;
   // Bus addresses
   localparam logic [3:0] PVB_DEV_ADDR_RST = 4'h2;
   localparam logic [3:0] PVB_BCAST_MEM = 4'hE;
   localparam logic [3:0] PVB_BCAST_CPU = 4'hF;
   // Broadcast acceptance settings
   localparam logic [1:0] PVB_AC_BOTH = 2'h0;
   localparam logic [1:0] PVB_AC_MEM_ONLY = 2'h1;
   localparam logic [1:0] PVB_AC_CPU_ONLY = 2'h2;
   localparam logic [1:0] PVB_AC_NONE = 2'h3;
   // Link commands
   localparam logic [4:0] PVB_CMD_SETVID_FAST = 5'h01;
   localparam logic [4:0] PVB_CMD_SETVID_SLOW = 5'h02;
   localparam logic [4:0] PVB_CMD_SET_PS = 5'h03;
   localparam logic [4:0] PVB_CMD_SET_WP = 5'h09;
   localparam int PVB_FRAME_BITS = 17;
   // Resolution and slew arithmetic
   localparam int PVB_RES_FINE_MV = 5;
   localparam int PVB_RES_COARSE_MV = 10;
   localparam int PVB_RATE_MIN_MVUS = 10;
   localparam int PVB_RATE_STEP_MVUS = 5;
   localparam int PVB_RATE_MAX_MVUS = 80;
   localparam int PVB_CLK_PERIOD_NS = 5;
   localparam int PVB_REF_FRAC = 16;
   // Reference counts in 1/16 uV; one mV/us equals one uV/ns
   localparam int PVB_STEP_PER_MVUS = PVB_CLK_PERIOD_NS * PVB_REF_FRAC;
   localparam int PVB_UNITS_PER_MV = 1000 * PVB_REF_FRAC;
   localparam int PVB_REF_W = 27;
   localparam int PVB_STEP_W = 14;
   // Reset values of configuration
   localparam logic [7:0] PVB_BOOT_RST = 8'h00;
   localparam logic [7:0] PVB_WP_RST = 8'h00;

   typedef struct packed {
      logic [1:0] slow_fac;   // 0:1/2 1:1/4 2:1/8 3:1/16
      logic [3:0] fast_sel;
      logic boot_sel;
      logic res_10mv;
      logic gen_b;
      logic ac_auto;
      logic rail_mem;
      logic [1:0] ac_mode;
      logic [3:0] dev_addr;
   } pvb_cfg_t;

   localparam pvb_cfg_t PVB_CFG_RST = '{slow_fac: 2'h0, fast_sel: 4'h0, boot_sel: 1'b0,
      res_10mv: 1'b0, gen_b: 1'b0, ac_auto: 1'b0, rail_mem: 1'b0, ac_mode: PVB_AC_BOTH,
      dev_addr: PVB_DEV_ADDR_RST};

   typedef struct packed {
      logic [3:0] addr;
      logic [4:0] cmd;
      logic [7:0] data;
   } pvb_frame_t;
endpackage

// [hdl/pvb_slave.sv]
// Voltage-code bus slave: link receiver, reference ramp and AXI4-Lite registers
// What this block does
// [RULE1] Link uses three wires: clock, two-way data, active-low alert from us.
// [RULE2] Device address resets to 02h and is rewritable in configuration.
// [RULE3] Broadcast acceptance: both 0E and 0F, 0E only, 0F only, none.
// [RULE4] Processor-core rail answers broadcast 0F; memory rail answers 0E.
// [RULE5] Older generation by mode bit; boot voltage selectable from boot register. Code boots before boot_sel can be set, so always to code 00h.
// [RULE6] Older generation can use 10 mV per code via a configuration bit.
// [RULE7] Newer generation boots from boot register; resolution 5 or 10 mV. Code boots before gen_b can be set, so always to code 00h.
// [RULE8] Broadcast set-work-point moves the rail to the work-point register target.
// [RULE9] Work-point moves use common slew and common power state.
// [RULE10] Sixteen fast slew settings spanning 10 to 80 mV/us. Code steps 5 mV/us from 10, so settings 14 and 15 both give 80 mV/us.
// [RULE11] Slow slew is fast slew times 1/2, 1/4, 1/8 or 1/16.
// [RULE12] Reference ramps to new code at chosen rate; alert marks completion.
// [RULE13] Processor addresses one rail directly or all rails by broadcast.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module pvb_slave
   import pvb_pkg::*;
(
   input wire logic clk_sys,                  // System clock, 200 MHz
   input wire logic rst,                      // Synchronous reset, active high
   input wire logic link_clk_i,               // Link clock pin from processor
   input wire logic link_data_i,              // Link data pin level
   output logic link_data_o,                  // Link data drive level
   output logic link_data_oe,                 // Link data drive enable
   output logic alert_n_o,                    // Alert drive level, active low
   output logic alert_oe,                     // Alert drive enable
   output logic [PVB_REF_W-1:0] ref_o,        // Reference, 1/16 uV units
   input wire logic [7:0] s_axi_awaddr,       // AXI write address
   input wire logic s_axi_awvalid,            // AXI write address valid
   output logic s_axi_awready,                // AXI write address ready
   input wire logic [31:0] s_axi_wdata,       // AXI write data
   input wire logic [3:0] s_axi_wstrb,        // AXI write strobes
   input wire logic s_axi_wvalid,             // AXI write data valid
   output logic s_axi_wready,                 // AXI write data ready
   output logic [1:0] s_axi_bresp,            // AXI write response
   output logic s_axi_bvalid,                 // AXI write response valid
   input wire logic s_axi_bready,             // AXI write response ready
   input wire logic [7:0] s_axi_araddr,       // AXI read address
   input wire logic s_axi_arvalid,            // AXI read address valid
   output logic s_axi_arready,                // AXI read address ready
   output logic [31:0] s_axi_rdata,           // AXI read data
   output logic [1:0] s_axi_rresp,            // AXI read response
   output logic s_axi_rvalid,                 // AXI read data valid
   input wire logic s_axi_rready              // AXI read data ready
);
   import pvb_pkg::*;

   typedef enum logic [1:0] {PVB_L_IDLE, PVB_L_SHIFT, PVB_L_ACK_WAIT, PVB_L_ACK} pvb_lstate_t;

   function automatic logic [PVB_STEP_W-1:0] fast_step(input logic [3:0] sel);
      int rate;
      rate = PVB_RATE_MIN_MVUS + PVB_RATE_STEP_MVUS * int'(sel);
      if (rate > PVB_RATE_MAX_MVUS) begin
         rate = PVB_RATE_MAX_MVUS;
      end
      return PVB_STEP_W'(rate * PVB_STEP_PER_MVUS);
   endfunction

   function automatic logic [PVB_REF_W-1:0] code_to_ref(input logic [7:0] code,
                                                        input logic coarse);
      int res;
      res = coarse ? PVB_RES_COARSE_MV : PVB_RES_FINE_MV;
      return PVB_REF_W'(int'(code) * res * PVB_UNITS_PER_MV);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Registers
   pvb_cfg_t cfg_q;
   logic [7:0] boot_q;
   logic [7:0] wp_q [PVB_WP_NUM];
   logic [7:0] tgt_code_q;
   logic [PVB_REF_W-1:0] tgt_ref_q;
   logic [PVB_REF_W-1:0] ref_q;
   logic [PVB_STEP_W-1:0] step_q;
   logic slow_q;
   logic [1:0] ps_q;
   logic busy_q;
   logic boot_go_q;
   logic done_q;

   // Link sampling: first stage feeds only the second
   logic lck_m_q, lck_s_q, lck_p_q, ldat_m_q, ldat_s_q;
   logic lck_rise, lck_fall;
   pvb_lstate_t lst_q;
   logic [4:0] bit_cnt_q;
   logic [PVB_FRAME_BITS-1:0] shift_q;
   pvb_frame_t frame;
   logic frame_end, is_bcast, accept;
   logic acc_e, acc_f;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lck_m_q <= 1'b0;
         lck_s_q <= 1'b0;
         lck_p_q <= 1'b0;
         ldat_m_q <= 1'b1;
         ldat_s_q <= 1'b1;
      end else begin
         lck_m_q <= link_clk_i;   // [RULE1]
         lck_s_q <= lck_m_q;
         lck_p_q <= lck_s_q;
         ldat_m_q <= link_data_i;
         ldat_s_q <= ldat_m_q;
      end
   end

   assign lck_rise = lck_s_q & ~lck_p_q;
   assign lck_fall = ~lck_s_q & lck_p_q;
   assign frame = pvb_frame_t'({shift_q[PVB_FRAME_BITS-2:0], ldat_s_q});
   assign frame_end = (lst_q == PVB_L_SHIFT) && lck_rise
                      && (bit_cnt_q == 5'(PVB_FRAME_BITS - 1));

   // Broadcast acceptance: auto follows rail type, else the explicit setting
   assign acc_e = cfg_q.ac_auto ? cfg_q.rail_mem                             // [RULE4]
                  : (cfg_q.ac_mode == PVB_AC_BOTH || cfg_q.ac_mode == PVB_AC_MEM_ONLY); // [RULE3]
   assign acc_f = cfg_q.ac_auto ? ~cfg_q.rail_mem                            // [RULE4]
                  : (cfg_q.ac_mode == PVB_AC_BOTH || cfg_q.ac_mode == PVB_AC_CPU_ONLY); // [RULE3]
   assign is_bcast = (frame.addr == PVB_BCAST_MEM && acc_e)
                     || (frame.addr == PVB_BCAST_CPU && acc_f);
   // Work point is only honoured through a broadcast address
   assign accept = frame_end && (is_bcast                                    // [RULE13]
                   || (frame.addr == cfg_q.dev_addr && frame.cmd != PVB_CMD_SET_WP)); // [RULE2]

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lst_q <= PVB_L_IDLE;
         bit_cnt_q <= 5'h00;
         shift_q <= '0;
         link_data_o <= 1'b1;
         link_data_oe <= 1'b0;
      end else begin
         unique case (lst_q)
            PVB_L_IDLE: begin
               if (lck_rise && !ldat_s_q) begin
                  lst_q <= PVB_L_SHIFT;
                  bit_cnt_q <= 5'h00;
               end
            end
            PVB_L_SHIFT: begin
               if (lck_rise) begin
                  shift_q <= {shift_q[PVB_FRAME_BITS-2:0], ldat_s_q};
                  bit_cnt_q <= bit_cnt_q + 5'h01;
                  if (frame_end) begin
                     lst_q <= accept ? PVB_L_ACK_WAIT : PVB_L_IDLE;
                  end
               end
            end
            PVB_L_ACK_WAIT: begin
               if (lck_fall) begin
                  lst_q <= PVB_L_ACK;
                  link_data_o <= 1'b0;   // [RULE1]
                  link_data_oe <= 1'b1;
               end
            end
            PVB_L_ACK: begin
               if (lck_fall) begin
                  lst_q <= PVB_L_IDLE;
                  link_data_o <= 1'b1;
                  link_data_oe <= 1'b0;
               end
            end
         endcase
      end
   end

   // Ramp control: one command source per cycle, boot after reset release
   logic [1:0] wp_idx;
   logic [7:0] new_code;
   logic [PVB_REF_W-1:0] diff;
   assign wp_idx = frame.data[1:0];
   assign new_code = (frame.cmd == PVB_CMD_SET_WP) ? wp_q[wp_idx] : frame.data;  // [RULE8]
   assign diff = (ref_q > tgt_ref_q) ? ref_q - tgt_ref_q : tgt_ref_q - ref_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         boot_go_q <= 1'b1;
         tgt_code_q <= 8'h00;
         tgt_ref_q <= '0;
         step_q <= '0;
         slow_q <= 1'b0;
         ps_q <= 2'h0;
      end else begin
         boot_go_q <= 1'b0;
         if (boot_go_q) begin
            // Boot runs on reset configuration: gen_b and boot_sel are 0, so it always boots from zero
            tgt_code_q <= (cfg_q.gen_b || cfg_q.boot_sel) ? boot_q : 8'h00;     // [RULE5] [RULE7]
            tgt_ref_q <= code_to_ref((cfg_q.gen_b || cfg_q.boot_sel) ? boot_q : 8'h00,
                                     cfg_q.res_10mv);
            step_q <= fast_step(cfg_q.fast_sel);
            slow_q <= 1'b0;
         end else if (accept) begin
            if (frame.cmd == PVB_CMD_SET_PS) begin
               ps_q <= frame.data[1:0];
            end else if (frame.cmd == PVB_CMD_SETVID_FAST || frame.cmd == PVB_CMD_SET_WP
                         || frame.cmd == PVB_CMD_SETVID_SLOW) begin
               tgt_code_q <= new_code;
               tgt_ref_q <= code_to_ref(new_code, cfg_q.res_10mv);              // [RULE6] [RULE7]
               if (frame.cmd == PVB_CMD_SETVID_SLOW) begin
                  // Shift kept at three bits so the 1/16 factor does not wrap to zero
                  step_q <= fast_step(cfg_q.fast_sel)
                            >> ({1'b0, cfg_q.slow_fac} + 3'h1);                 // [RULE11]
                  slow_q <= 1'b1;
               end else begin
                  step_q <= fast_step(cfg_q.fast_sel);                          // [RULE10]
                  slow_q <= 1'b0;
               end
               if (frame.cmd == PVB_CMD_SET_WP) begin
                  ps_q <= 2'h0;                                                 // [RULE9]
               end
            end
         end
      end
   end

   // Reference ramp; done pulses once when the target is reached
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ref_q <= '0;
         ref_o <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         ref_o <= ref_q;
         if (ref_q != tgt_ref_q) begin
            busy_q <= 1'b1;
            if (diff <= PVB_REF_W'(step_q)) begin
               ref_q <= tgt_ref_q;                                              // [RULE12]
               done_q <= 1'b1;
               busy_q <= 1'b0;
            end else if (ref_q < tgt_ref_q) begin
               ref_q <= ref_q + PVB_REF_W'(step_q);
            end else begin
               ref_q <= ref_q - PVB_REF_W'(step_q);
            end
         end else begin
            busy_q <= 1'b0;
         end
      end
   end

   // Alert: set on completion wins over the clear by an accepted frame
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         alert_n_o <= 1'b1;
         alert_oe <= 1'b0;
      end else if (done_q) begin
         alert_n_o <= 1'b0;                                                     // [RULE12]
         alert_oe <= 1'b1;
      end else if (accept) begin
         alert_n_o <= 1'b1;
         alert_oe <= 1'b0;
      end
   end

   // AXI4-Lite write channel
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go, wr_map;
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_map = aw_addr_q == PVB_OFF_CFG || aw_addr_q == PVB_OFF_BOOT
                   || (aw_addr_q >= PVB_OFF_WP0 && aw_addr_q < PVB_OFF_STATUS
                       && aw_addr_q[1:0] == 2'h0);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_q <= PVB_CFG_RST;                                                  // [RULE2]
         boot_q <= PVB_BOOT_RST;
         for (int i = 0; i < PVB_WP_NUM; i++) begin
            wp_q[i] <= PVB_WP_RST;
         end
      end else if (wr_go) begin
         if (aw_addr_q == PVB_OFF_CFG) begin
            cfg_q <= pvb_cfg_t'(merge(32'(cfg_q), w_data_q, w_strb_q));
         end
         if (aw_addr_q == PVB_OFF_BOOT) begin
            boot_q <= 8'(merge({24'h0, boot_q}, w_data_q, w_strb_q));
         end
         for (int i = 0; i < PVB_WP_NUM; i++) begin
            if (aw_addr_q == PVB_OFF_WP0 + 8'(4 * i)) begin
               wp_q[i] <= 8'(merge({24'h0, wp_q[i]}, w_data_q, w_strb_q));
            end
         end
      end
   end

   // AXI4-Lite read channel
   logic [31:0] rd_val;
   logic rd_ok;
   always_comb begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         PVB_OFF_CFG: rd_val = 32'(cfg_q);
         PVB_OFF_BOOT: rd_val = {24'h0, boot_q};
         PVB_OFF_WP0: rd_val = {24'h0, wp_q[0]};
         PVB_OFF_WP0 + 8'h04: rd_val = {24'h0, wp_q[1]};
         PVB_OFF_WP0 + 8'h08: rd_val = {24'h0, wp_q[2]};
         PVB_OFF_WP0 + 8'h0C: rd_val = {24'h0, wp_q[3]};
         PVB_OFF_STATUS: rd_val = {19'h0, slow_q, ps_q, ~alert_n_o, busy_q, tgt_code_q};
         PVB_OFF_REF: rd_val = 32'(ref_q);
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   ack_drive_low_a: assert property (link_data_oe // [RULE1]
      |-> !link_data_o && lst_q == PVB_L_ACK)
      else $error("link data driven without a low acknowledge");
   addr_reset_a: assert property ($fell(rst) |-> cfg_q.dev_addr == PVB_DEV_ADDR_RST) // [RULE2]
      else $error("device address not at reset value");
   bcast_none_a: assert property (frame_end && !cfg_q.ac_auto // [RULE3]
      && cfg_q.ac_mode == PVB_AC_NONE && frame.addr != cfg_q.dev_addr |-> !accept)
      else $error("broadcast taken while disabled");
   rail_type_a: assert property (frame_end && cfg_q.ac_auto // [RULE4]
      && frame.cmd != PVB_CMD_SET_WP
      && frame.addr == (cfg_q.rail_mem ? PVB_BCAST_MEM : PVB_BCAST_CPU) |-> accept)
      else $error("rail broadcast address ignored");
   boot_source_a: assert property (boot_go_q |=> tgt_code_q == // [RULE5]
      ($past(cfg_q.gen_b) || $past(cfg_q.boot_sel) ? $past(boot_q) : 8'h00))
      else $error("boot target from wrong source");
   code_scale_a: assert property (accept && frame.cmd == PVB_CMD_SETVID_FAST |=> // [RULE7]
      tgt_ref_q == code_to_ref(tgt_code_q, cfg_q.res_10mv) && !slow_q)
      else $error("target reference scaled wrongly");
   work_point_a: assert property (accept && frame.cmd == PVB_CMD_SET_WP // [RULE8]
      && !boot_go_q |=> tgt_code_q == $past(wp_q[wp_idx]) && ps_q == 2'h0 && !slow_q)
      else $error("work point not applied uniformly");
   slew_step_a: assert property (busy_q && ref_q < tgt_ref_q // [RULE10]
      && tgt_ref_q - ref_q > PVB_REF_W'(step_q) && $stable(tgt_ref_q)
      |=> ref_q == $past(ref_q) + PVB_REF_W'($past(step_q)) || $changed(tgt_ref_q))
      else $error("ramp step differs from selected rate");
   slow_factor_a: assert property (accept && frame.cmd == PVB_CMD_SETVID_SLOW // [RULE11]
      && !boot_go_q |=> step_q == fast_step(cfg_q.fast_sel) >> ({1'b0, cfg_q.slow_fac} + 3'h1))
      else $error("slow step not a fraction of fast step");
   done_alert_a: assert property (done_q |-> ##1 !alert_n_o ##0 alert_oe) // [RULE12]
      else $error("completion did not raise alert");

   wp_seen_c: cover property (accept && frame.cmd == PVB_CMD_SET_WP);
   slow_done_c: cover property (slow_q && done_q);
   ack_sent_c: cover property (lst_q == PVB_L_ACK ##[1:200] lst_q == PVB_L_IDLE);
endmodule

// [testbench/pvb_host_model.sv]
// Host processor model: link clock and data, pulled-up open-drain wires
`timescale 1ns/10ps
module pvb_host_model
   import pvb_pkg::*;
(
   output logic link_clk,           // Link clock, still between frames
   output logic link_wire,          // Resolved data wire
   output logic alert_wire,         // Resolved alert wire
   input wire logic slv_data,       // Slave data level
   input wire logic slv_oe,         // Slave data enable
   input wire logic slv_alert_n,    // Slave alert level
   input wire logic slv_alert_oe    // Slave alert enable
);
   logic host_oe;
   logic host_d;
   // Released lines float to the pull-up, never to a stale level
   assign link_wire = host_oe ? host_d : (slv_oe ? slv_data : 1'b1);
   assign alert_wire = slv_alert_oe ? slv_alert_n : 1'b1;
   initial begin
      link_clk = 1'b0;
      host_oe = 1'b0;
      host_d = 1'b1;
   end
   // Address is one rail or a broadcast, chosen by the caller
   task automatic send(input pvb_frame_t f, output logic acked);
      host_oe = 1'b1;
      host_d = 1'b0;
      #31 link_clk = 1'b1;
      for (int i = 16; i >= 0; i--) begin
         #62.5 link_clk = 1'b0;
         host_d = f[i];
         #62.5 link_clk = 1'b1;
      end
      #62.5 link_clk = 1'b0;
      host_oe = 1'b0;
      #62.5 link_clk = 1'b1;
      acked = !link_wire;
      #62.5 link_clk = 1'b0;
      #125;
   endtask
endmodule

// [testbench/tb_top.sv]
// Bench: AXI4-Lite register access and link frames against the slave
`timescale 1ns/10ps
module tb_top;
   import pvb_pkg::*;
   localparam logic [3:0] AC_E = 4'b0011;
   localparam logic [3:0] AC_F = 4'b0101;
   localparam int RSEL [4] = '{0, 15, 2, 5};
   localparam int RFAC [4] = '{0, 0, 3, 1};
   logic clk_sys, rst, lclk, lwire, awire, d_o, d_oe, al_n, al_oe;
   logic [PVB_REF_W-1:0] ref_o;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   pvb_cfg_t cfg;
   int fail_count, tests_run;
   pvb_slave i_pvb_slave (.clk_sys(clk_sys), .rst(rst), .link_clk_i(lclk),
      .link_data_i(lwire), .link_data_o(d_o), .link_data_oe(d_oe), .alert_n_o(al_n),
      .alert_oe(al_oe), .ref_o(ref_o), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   pvb_host_model i_pvb_host_model (.link_clk(lclk), .link_wire(lwire), .alert_wire(awire),
      .slv_data(d_o), .slv_oe(d_oe), .slv_alert_n(al_n), .slv_alert_oe(al_oe));
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic summarize();
      if (fail_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic pa, pw, pb;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pb = 1'b0;
      while (!pb) begin
         @(negedge clk_sys);
         pa = awvalid && awready;
         pw = wvalid && wready;
         pb = bvalid;
         r = bresp;
         @(posedge clk_sys);
         if (pa) awvalid <= 1'b0;
         if (pw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic pa, pr;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      pr = 1'b0;
      while (!pr) begin
         @(negedge clk_sys);
         pa = arvalid && arready;
         pr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk_sys);
         if (pa) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   task automatic setc();
      logic [1:0] r;
      wr(PVB_OFF_CFG, 32'(cfg), r);
   endtask
   task automatic fr(input logic [3:0] a, input logic [4:0] c, input logic [7:0] d,
         input logic e);
      logic k;
      i_pvb_host_model.send('{addr: a, cmd: c, data: d}, k);
      check("ack", k, e);
   endtask
   // Bounded wait; a ramp that never ends shows as a mismatch
   task automatic wait_alert();
      int n;
      n = 0;
      while (awire !== 1'b0 && n < 20000) begin
         @(posedge clk_sys);
         n++;
      end
      check("alert", awire, 1'b0);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #300000;
      fail_count++;
      summarize();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int s, e;
      {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hF;
      fail_count = 0;
      tests_run = 0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd(PVB_OFF_CFG, d, r);
      check("cfg_rst", d, 32'(PVB_CFG_RST));
      rd(PVB_OFF_STATUS, d, r);
      check("boot", d[7:0], PVB_BOOT_RST);
      rd(8'h40, d, r);
      check("unmapped", r, 2'b10);
      wr(PVB_OFF_REF, 32'h0, r);
      check("ro_write", r, 2'b10);
      fr(PVB_DEV_ADDR_RST, PVB_CMD_SETVID_FAST, 8'h10, 1'b1);
      fr(4'h3, PVB_CMD_SETVID_FAST, 8'h20, 1'b0);
      wait_alert();
      check("ref", 32'(ref_o), 32'(16 * PVB_RES_FINE_MV * PVB_UNITS_PER_MV));
      cfg = PVB_CFG_RST;
      cfg.dev_addr = 4'h5;
      setc();
      fr(4'h2, PVB_CMD_SET_PS, 8'h00, 1'b0);
      fr(4'h5, PVB_CMD_SET_PS, 8'h00, 1'b1);
      check("alert_clr", awire, 1'b1);
      cfg.dev_addr = PVB_DEV_ADDR_RST;
      for (int m = 0; m < 4; m++) begin
         cfg.ac_mode = 2'(m);
         setc();
         fr(PVB_BCAST_MEM, PVB_CMD_SET_PS, 8'h00, AC_E[m]);
         fr(PVB_BCAST_CPU, PVB_CMD_SET_PS, 8'h00, AC_F[m]);
      end
      cfg.ac_mode = PVB_AC_NONE;
      cfg.ac_auto = 1'b1;
      for (int m = 0; m < 2; m++) begin
         cfg.rail_mem = 1'(m);
         setc();
         fr(PVB_BCAST_MEM, PVB_CMD_SET_PS, 8'h00, 1'(m));
         fr(PVB_BCAST_CPU, PVB_CMD_SET_PS, 8'h00, 1'(1 - m));
      end
      cfg.ac_auto = 1'b0;
      cfg.ac_mode = PVB_AC_BOTH;
      setc();
      wr(PVB_OFF_WP0 + 8'h08, 32'h33, r);
      fr(4'h2, PVB_CMD_SET_PS, 8'h01, 1'b1);
      fr(4'h2, PVB_CMD_SETVID_SLOW, 8'h10, 1'b1);
      fr(4'h2, PVB_CMD_SET_WP, 8'h02, 1'b0);
      fr(PVB_BCAST_CPU, PVB_CMD_SET_WP, 8'h02, 1'b1);
      rd(PVB_OFF_STATUS, d, r);
      check("wp_target", d[7:0], 8'h33);
      check("wp_state", d[12:10], 3'h0);
      wait_alert();
      check("wp_ref", 32'(ref_o), 32'(8'h33 * PVB_RES_FINE_MV * PVB_UNITS_PER_MV));
      for (int g = 0; g < 2; g++) begin
         cfg.gen_b = 1'(g);
         cfg.res_10mv = 1'b1;
         setc();
         fr(4'h2, PVB_CMD_SETVID_FAST, 8'(32 + g), 1'b1);
         wait_alert();
         check("ref_10", 32'(ref_o),
            32'((32 + g) * PVB_RES_COARSE_MV * PVB_UNITS_PER_MV));
      end
      // Step per cycle sampled mid-ramp; direction alternates
      for (int k = 0; k < 4; k++) begin
         cfg.fast_sel = 4'(RSEL[k]);
         cfg.slow_fac = 2'(RFAC[k]);
         setc();
         fr(4'h2, k > 1 ? PVB_CMD_SETVID_SLOW : PVB_CMD_SETVID_FAST,
            k[0] ? 8'h00 : 8'hC0, 1'b1);
         repeat (20) @(negedge clk_sys);
         s = int'(ref_o);
         @(negedge clk_sys);
         s = int'(ref_o) - s;
         s = s < 0 ? -s : s;
         e = PVB_RATE_MIN_MVUS + PVB_RATE_STEP_MVUS * RSEL[k];
         e = (e > PVB_RATE_MAX_MVUS ? PVB_RATE_MAX_MVUS : e) * PVB_STEP_PER_MVUS;
         if (k > 1) e = e >> (RFAC[k] + 1);
         check("step", 32'(s), 32'(e));
      end
      summarize();
   end
endmodule
